// ==== hw/ushr_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : shared constants and types for the 4-bit universal shift register
// Assumes : one 20 MHz system clock, synchronous active-high reset
// Notes   : mode codes are {mode_select_upper, mode_select_lower}
//////////////////////////////////////////////////////////////////////////////
package ushr_pkg;

  // stage count and pin synchroniser depth
  localparam int unsigned STAGE_COUNT = 4;
  localparam int unsigned SYNC_DEPTH  = 2;

  // command buffer depth between the pin sampler and the stages
  localparam int unsigned CMD_DEPTH   = 32;

  // clock period in ns, for reference by timing users
  localparam int unsigned CLK_PERIOD_NS = 50;

  // value of the stages after reset or clear
  localparam logic [3:0] STAGE_RESET = 4'h0;

  // mode codes {upper, lower}
  localparam logic [1:0] MODE_HOLD  = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT  = 2'h2;
  localparam logic [1:0] MODE_LOAD  = 2'h3;

  // one sampled clock edge: mode, serial inputs and parallel word
  typedef struct packed {
    logic [1:0] mode;
    logic       serial_left;
    logic       serial_right;
    logic [3:0] parallel;
  } ushr_cmd_t;

  localparam int unsigned CMD_WIDTH = $bits(ushr_cmd_t);

endpackage

// ==== hw/ushr_fifo.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : synchronous valid/ready fifo, flip-flop storage
// Assumes : single clock, synchronous active-high reset and flush
// Notes   : full and empty come straight from the occupancy count
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps
module ushr_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             flush,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  // wrap a pointer at the configured depth, depth need not be a power of two
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // handshake terms
  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_ptr_r];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and count; flush drops everything still queued
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= next_ptr(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= next_ptr(rd_ptr_r);
      end
      if (push && !pop) begin
        count_r <= count_r + (AW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end

endmodule

// ==== hw/ushr_top.sv ====
//////////////////////////////////////////////////////////////////////////////
// Purpose : 4-bit bidirectional universal shift register with a sampled clock pin
// Assumes : all register pins are asynchronous to clk and pass two flip-flops
// Notes   : each rising edge of the register clock pin outside hold mode and clear is queued as a command,
//           and applied in order one per clk, faster than the sampler can see edges, so the queue never holds more than one
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/100ps

// Overview of operation
// - four stages, shift both ways, parallel load
// - clear low forces all stages low
// - clock low with clear high: stages hold
// - apart from clear and reset, stages change only on rising clock edge
// - both selects high: load parallel inputs
// - upper low, lower high: shift right
// - upper high, lower low: shift left
// - both selects low: stages hold unchanged
module ushr_top #(
  parameter int unsigned CMD_DEPTH = ushr_pkg::CMD_DEPTH
) (
  // system clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register control pins
  input  wire logic       reg_clock,
  input  wire logic       clear_n,
  input  wire logic       mode_select_upper,
  input  wire logic       mode_select_lower,
  // serial and parallel data pins
  input  wire logic       serial_left,
  input  wire logic       serial_right,
  input  wire logic [3:0] parallel_in,
  // stage outputs
  output logic            stage_first_out,
  output logic            stage_second_out,
  output logic            stage_third_out,
  output logic            stage_last_out,
  // command queue status
  output logic            cmd_ready,
  output logic            cmd_pending
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int unsigned PIN_W = 10;

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] meta_r;
  logic [PIN_W-1:0] sync_r;
  logic             clock_s;
  logic             clear_n_s;
  logic [1:0]       mode_s;
  logic             left_s;
  logic             right_s;
  logic [3:0]       par_s;

  assign pins = {reg_clock, clear_n, mode_select_upper, mode_select_lower,
                 serial_left, serial_right, parallel_in};

  // first stage feeds only the second; reset parks clear asserted and clock low
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins;
      sync_r <= meta_r;
    end
  end

  assign clock_s   = sync_r[9];
  assign clear_n_s = sync_r[8];
  assign mode_s    = sync_r[7:6];
  assign left_s    = sync_r[5];
  assign right_s   = sync_r[4];
  assign par_s     = sync_r[3:0];

  //////////////////////////////////////////////////////////////////////////////
  // register clock edge detection

  logic clock_prev_r;
  logic clock_rise;

  // previous synchronised level, starts low so a pin held high after reset
  // counts as one rising edge, as a real flop would see on power up
  always_ff @(posedge clk) begin
    if (rst) begin
      clock_prev_r <= 1'b0;
    end else begin
      clock_prev_r <= clock_s;
    end
  end

  // only the low-to-high transition is active; falling and steady high are ignored
  assign clock_rise = clock_s && !clock_prev_r;

  //////////////////////////////////////////////////////////////////////////////
  // command capture and queue

  ushr_pkg::ushr_cmd_t cmd_in;
  ushr_pkg::ushr_cmd_t cmd_out;
  logic                cmd_push;
  logic                cmd_valid;
  logic                cmd_take;
  logic                clearing;

  assign clearing = !clear_n_s;

  // hold mode commands change nothing, so they are not queued at all
  assign cmd_push = clock_rise && clear_n_s && (mode_s != ushr_pkg::MODE_HOLD);

  // steady levels at the edge are bundled with it
  always_comb begin
    cmd_in.mode         = mode_s;
    cmd_in.serial_left  = left_s;
    cmd_in.serial_right = right_s;
    cmd_in.parallel     = par_s;
  end

  // a full queue drops the edge; cmd_ready tells the driver to slow down
  ushr_fifo #(
    .WIDTH (ushr_pkg::CMD_WIDTH),
    .DEPTH (CMD_DEPTH)
  ) u_cmd_fifo (
    .clk       (clk),
    .rst       (rst),
    .flush     (clearing),
    .in_valid  (cmd_push),
    .in_ready  (cmd_ready),
    .in_data   (cmd_in),
    .out_valid (cmd_valid),
    .out_ready (cmd_take),
    .out_data  (cmd_out)
  );

  // the stages drain one command per cycle, except while clear is held
  assign cmd_take    = !clearing;
  assign cmd_pending = cmd_valid;

  //////////////////////////////////////////////////////////////////////////////
  // stage update

  logic [3:0] stage_r; // bit 0 is the first stage, bit 3 the last

  // next stage value for one command
  function automatic logic [3:0] apply_cmd(input logic [3:0] cur,
                                           input ushr_pkg::ushr_cmd_t c);
    unique case (c.mode)
      ushr_pkg::MODE_LOAD:  apply_cmd = c.parallel;
      ushr_pkg::MODE_RIGHT: apply_cmd = {cur[2:0], c.serial_right};
      ushr_pkg::MODE_LEFT:  apply_cmd = {c.serial_left, cur[3:1]};
      ushr_pkg::MODE_HOLD:  apply_cmd = cur;
    endcase
  endfunction

  // clear dominates everything; otherwise only queued rising edges act
  always_ff @(posedge clk) begin
    if (rst) begin
      stage_r <= ushr_pkg::STAGE_RESET;
    end else if (clearing) begin
      stage_r <= ushr_pkg::STAGE_RESET;
    end else if (cmd_valid) begin
      stage_r <= apply_cmd(stage_r, cmd_out);
    end
    // no command: clock low or high with no new edge keeps the stages
  end

  //////////////////////////////////////////////////////////////////////////////
  // stage outputs

  // outputs are the stage flops themselves
  assign stage_first_out  = stage_r[0];
  assign stage_second_out = stage_r[1];
  assign stage_third_out  = stage_r[2];
  assign stage_last_out   = stage_r[3];

endmodule

// ==== testbench/ushr_sva.sv ====
// Purpose: assertions on the shift register pins and stages
// Assumes: pins held 3 clk either side of each register clock rise
// Notes: result windows allow for sampler and queue latency
`timescale 1ns/100ps
module ushr_sva (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // register pins
  input wire logic       reg_clock,
  input wire logic       clear_n,
  input wire logic       mode_select_upper,
  input wire logic       mode_select_lower,
  input wire logic       serial_left,
  input wire logic       serial_right,
  input wire logic [3:0] parallel_in,
  // stages and queue status
  input wire logic       stage_first_out,
  input wire logic       stage_second_out,
  input wire logic       stage_third_out,
  input wire logic       stage_last_out,
  input wire logic       cmd_ready,
  input wire logic       cmd_pending
);
  // stage vector with the first stage in bit 0
  wire logic [3:0] q = {stage_last_out, stage_third_out, stage_second_out, stage_first_out};
  wire logic [1:0] m = {mode_select_upper, mode_select_lower};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // only an edge seen on an empty queue is judged, so queued work cannot blur the result;
  // the stages show it four clk after the rise is first sampled, pins stand still meanwhile
  rst_clean_a: assert property ($fell(rst) |-> q == 4'h0 && cmd_ready && !cmd_pending)
    else $error("stages or queue not clean after reset");
  clr_force_a: assert property (!clear_n [*4] |-> q == 4'h0)
    else $error("clear did not empty the stages");
  idle_hold_a: assert property ((clear_n && !reg_clock && !cmd_pending) [*6] |-> $stable(q))
    else $error("stages moved with register clock low");
  edge_only_a: assert property (q != $past(q) && q != 4'h0 |-> $past(cmd_pending))
    else $error("stages moved without a queued edge");
  load_apply_a: assert property ($rose(reg_clock) && clear_n && !cmd_pending && m == 2'h3
    |-> ##4 q == $past(parallel_in, 4))
    else $error("parallel load result wrong");
  right_shift_a: assert property ($rose(reg_clock) && clear_n && !cmd_pending && m == 2'h1
    |-> ##4 q == {$past(q[2:0], 4), $past(serial_right, 4)})
    else $error("right shift result wrong");
  left_shift_a: assert property ($rose(reg_clock) && clear_n && !cmd_pending && m == 2'h2
    |-> ##4 q == {$past(serial_left, 4), $past(q[3:1], 4)})
    else $error("left shift result wrong");
  mode_hold_a: assert property ((clear_n && m == 2'h0 && !cmd_pending) [*6] |-> $stable(q))
    else $error("stages moved in hold mode");
  // main scenarios reached
  cover property ($rose(reg_clock) && m == 2'h3);
  cover property ($rose(reg_clock) && m == 2'h1);
  cover property ($rose(reg_clock) && m == 2'h2);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind ushr_top ushr_sva ushr_sva_inst (
  .clk(clk), .rst(rst), .reg_clock(reg_clock), .clear_n(clear_n),
  .mode_select_upper(mode_select_upper), .mode_select_lower(mode_select_lower),
  .serial_left(serial_left), .serial_right(serial_right), .parallel_in(parallel_in),
  .stage_first_out(stage_first_out), .stage_second_out(stage_second_out),
  .stage_third_out(stage_third_out), .stage_last_out(stage_last_out),
  .cmd_ready(cmd_ready), .cmd_pending(cmd_pending));

// ==== testbench/ushr_pins.sv ====
// Purpose: surrounding logic that drives the register pins
// Assumes: called just after a rising edge of clk
// Notes: data stays put 3 clk before and after each clock rise
`timescale 1ns/100ps
module ushr_pins (
  // system clock
  input wire logic  clk,
  // register pins
  output logic       reg_clock,
  output logic       clear_n,
  output logic [1:0] mode,
  output logic       serial_left,
  output logic       serial_right,
  output logic [3:0] parallel_in
);
  // clear held active until the bench releases it
  initial begin
    {reg_clock, clear_n, mode} = 4'h0;
    {serial_left, serial_right, parallel_in} = 6'h00;
  end
  // one register clock pulse; phases long enough for the two-flop sampler
  task automatic op(input logic [1:0] md, input logic sl, input logic sr, input logic [3:0] pd);
    mode <= md;
    serial_left <= sl;
    serial_right <= sr;
    parallel_in <= pd;
    repeat (3) @(posedge clk);
    reg_clock <= 1'b1;
    repeat (3) @(posedge clk);
    reg_clock <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // clear level, then time for it to pass the sampler
  task automatic clr(input logic v);
    clear_n <= v;
    repeat (4) @(posedge clk);
  endtask
endmodule

// ==== testbench/ushr_top_tb.sv ====
// Purpose: self-checking bench for the universal shift register
// Assumes: 20 MHz clk, all results settle within the fixed pin pulse
// Notes: e models the stages from the pin stimulus alone
`timescale 1ns/100ps
module ushr_top_tb;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  wire logic  rc, cn, sl, sr, rdy, pend;
  wire logic [1:0] md;
  wire logic [3:0] pd, q;
  logic [3:0] e;
  int         error_cnt = 0;
  int         total_checks = 0;
  // 50 ns period
  always #25 clk = ~clk;
  ushr_top ushr_top_inst (.clk(clk), .rst(rst), .reg_clock(rc), .clear_n(cn),
    .mode_select_upper(md[1]), .mode_select_lower(md[0]), .serial_left(sl), .serial_right(sr),
    .parallel_in(pd), .stage_first_out(q[0]), .stage_second_out(q[1]), .stage_third_out(q[2]),
    .stage_last_out(q[3]), .cmd_ready(rdy), .cmd_pending(pend));
  ushr_pins ushr_pins_inst (.clk(clk), .reg_clock(rc), .clear_n(cn), .mode(md),
    .serial_left(sl), .serial_right(sr), .parallel_in(pd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // reset leaves the stages empty and the queue idle, then clear is lifted
  task automatic t_reset();
    @(posedge clk);
    @(negedge clk);
    chk("reset", q, 4'h0);
    chk("ready", {3'h0, rdy}, 4'h1);
    chk("pending", {3'h0, pend}, 4'h0);
    @(posedge clk);
    ushr_pins_inst.clr(1'b1);
    $display("reset test done");
  endtask
  // serial inputs set opposite to the loaded word, so a leak shows;
  // the edge sits in the queue for one cycle, three clk after the pin rise
  task automatic t_load();
    fork
      ushr_pins_inst.op(2'h3, 1'b1, 1'b1, 4'hA);
      begin
        repeat (6) @(posedge clk);
        #1;
        chk("pending", {3'h0, pend}, 4'h1);
      end
    join
    chk("load", q, 4'hA);
    chk("pending", {3'h0, pend}, 4'h0);
    ushr_pins_inst.op(2'h3, 1'b0, 1'b0, 4'h5);
    e = 4'h5;
    chk("load", q, e);
    $display("load test done");
  endtask
  // four shifts replace every stage; parallel and the unused serial input must be ignored
  task automatic t_shift(input logic [1:0] m, input logic [3:0] pat);
    for (int i = 0; i < 4; i++) begin
      ushr_pins_inst.op(m, m[0] ? ~pat[i] : pat[i], m[0] ? pat[i] : ~pat[i], ~e);
      e = m[0] ? {e[2:0], pat[i]} : {pat[i], e[3:1]};
      chk(m[0] ? "right" : "left", q, e);
    end
    $display("shift test done");
  endtask
  // hold-mode edge, then a long quiet spell with the clock low
  task automatic t_hold();
    ushr_pins_inst.op(2'h0, 1'b1, 1'b1, ~e);
    chk("hold", q, e);
    repeat (20) @(posedge clk);
    chk("idle", q, e);
    $display("hold test done");
  endtask
  // a load while clear is low must be lost
  task automatic t_clear();
    ushr_pins_inst.clr(1'b0);
    chk("clear", q, 4'h0);
    ushr_pins_inst.op(2'h3, 1'b0, 1'b0, 4'hF);
    chk("clear", q, 4'h0);
    chk("pending", {3'h0, pend}, 4'h0);
    ushr_pins_inst.clr(1'b1);
    ushr_pins_inst.op(2'h3, 1'b0, 1'b0, 4'h6);
    chk("reload", q, 4'h6);
    $display("clear test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_load();
    t_shift(2'h1, 4'h9);
    t_shift(2'h2, 4'h6);
    t_hold();
    t_clear();
    results();
  end
endmodule
